//--- hdl/asc_pkg.sv
/*
 * shared constants and carrier types for the serial converter control block.
 * assumes a single 50 MHz system clock domain; pin inputs are synchronised in the block.
 */
package asc_pkg;
	// ======================================================================
	// frame and word layout
	localparam int RESULT_W = 10; // straight-binary result width
	localparam int CTRL_W = 8; // control byte width
	localparam int CONV_EDGES = 16; // serial clocks per conversion
	localparam int LEAD_ZEROS = 4; // falling edges of leading zeros
	localparam int RES_LAST_EDGE = 14; // last falling edge carrying result
	localparam int CHAN_HI = 5; // channel field msb in control byte
	localparam int CHAN_LO = 3; // channel field lsb in control byte
	localparam logic [2:0] CHAN_RESET = 3'h0; // first analog input after power-up
	localparam logic [RESULT_W-1:0] RESULT_EMPTY = 10'h000; // sent when no result is buffered
	localparam int CLK_MHZ = 50;

	// ======================================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic [RESULT_W-1:0] data;
	} asc_result_type;

	typedef struct packed {
		logic [2:0] cs_p; // [0] first sync flop, [1] second, [2] delayed copy
		logic [2:0] sclk_p;
		logic [1:0] din_p;
		logic [3:0] rise_cnt;
		logic [4:0] fall_cnt;
		logic [CTRL_W-1:0] ctl_shift;
		logic [2:0] chan_pend;
		logic [2:0] chan_cur;
		logic [RESULT_W-1:0] res_shift;
		logic dout;
		logic doze;
		logic track;
	} asc_state_type;
endpackage

//--- hdl/asc_buf2.sv
/*
 * two-entry buffer with valid/ready on both sides; read data come from a register.
 * assumes both sides run on clk and honour the handshake.
 */
`timescale 1ns/100ps
`default_nettype none
module asc_buf2
#(
	parameter int W = asc_pkg::RESULT_W
)
(
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} asc_buf_type;

	asc_buf_type buf_reg;
	asc_buf_type buf_next;
	logic push;
	logic pop;

	// handshakes; full refuses the source so nothing is overwritten
	assign in_ready = (buf_reg.cnt != 2'h2);
	assign out_valid = (buf_reg.cnt != 2'h0);
	assign out_data = buf_reg.mem[buf_reg.rp];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_ready & out_valid;

	// next state
	always_comb
	begin
		buf_next = buf_reg;
		if (push)
		begin
			buf_next.mem[buf_reg.wp] = in_data;
			buf_next.wp = ~buf_reg.wp;
		end
		if (pop)
			buf_next.rp = ~buf_reg.rp;
		buf_next.cnt = buf_reg.cnt + {1'b0, push} - {1'b0, pop};
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			buf_reg <= '0;
		else
			buf_reg <= buf_next;
	end
endmodule
`default_nettype wire

//--- hdl/asc_ctrl.sv
/*
 * digital control of an eight-channel 10-bit serial converter: pin framing,
 * channel select, result shifting and chip-select power control.
 * assumes the analog core pushes one result per conversion into res_* during the
 * track window and samples the channel on sample_chan while track is high.
 */
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl
(
	// clock, reset, freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// serial pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// analog core side
	output logic [2:0] sample_chan,
	output logic track,
	output logic powered,
	input wire logic res_valid,
	input wire logic [asc_pkg::RESULT_W-1:0] res_data,
	output logic res_ready
);
	asc_pkg::asc_state_type st_reg;
	asc_pkg::asc_state_type st_next;
	asc_pkg::asc_result_type head;
	logic head_pop;
	logic cs_low;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic [4:0] fall_idx;
	logic [asc_pkg::CTRL_W-1:0] ctl_byte;

	// ======================================================================
	// result buffer: a late shifter never loses a word the core delivered
	asc_buf2 #(.W(asc_pkg::RESULT_W)) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(res_valid),
		.in_data(res_data),
		.in_ready(res_ready),
		.out_valid(head.valid),
		.out_data(head.data),
		.out_ready(head_pop)
	);

	// ======================================================================
	// pin events, seen only from the second sync flop onward
	assign cs_low = ~st_reg.cs_p[1];
	assign cs_fall = ~st_reg.cs_p[1] & st_reg.cs_p[2];
	assign sclk_rise = cs_low & ~cs_fall & st_reg.sclk_p[1] & ~st_reg.sclk_p[2];
	// select falling with clock low counts as the first falling edge
	assign sclk_fall = cs_low & ((~cs_fall & ~st_reg.sclk_p[1] & st_reg.sclk_p[2]) | (cs_fall & ~st_reg.sclk_p[1]));
	assign fall_idx = (st_reg.fall_cnt == 5'(asc_pkg::CONV_EDGES)) ? 5'h01 : st_reg.fall_cnt + 5'h01;
	assign ctl_byte = {st_reg.ctl_shift[asc_pkg::CTRL_W-2:0], st_reg.din_p[1]};
	// hold starts on the last leading-zero falling edge (the fourth); take the buffered result then
	assign head_pop = ce & sclk_fall & (fall_idx == 5'(asc_pkg::LEAD_ZEROS));

	// ======================================================================
	// outputs
	assign dout = st_reg.dout;
	assign dout_oe = cs_low;
	assign powered = cs_low & ~st_reg.doze;
	assign sample_chan = st_reg.chan_cur;
	assign track = st_reg.track;

	// ======================================================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		if (ce)
		begin
			st_next.cs_p = {st_reg.cs_p[1:0], cs_n};
			st_next.sclk_p = {st_reg.sclk_p[1:0], sclk};
			st_next.din_p = {st_reg.din_p[0], din};
			if (!cs_low)
			begin
				// deselected: counters restart and the pin goes undriven
				st_next.rise_cnt = 4'h0;
				st_next.fall_cnt = 5'h00;
				st_next.track = 1'b0;
				st_next.doze = 1'b0;
				st_next.dout = 1'b0;
			end
			else
			begin
				if (sclk_rise)
				begin
					// four-bit count wraps every sixteen rises
					st_next.rise_cnt = st_reg.rise_cnt + 4'h1;
					if (st_reg.rise_cnt < 4'(asc_pkg::CTRL_W))
						st_next.ctl_shift = ctl_byte;
					if (st_reg.rise_cnt == 4'(asc_pkg::CTRL_W - 1))
						st_next.chan_pend = ctl_byte[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO];
				end
				if (sclk_fall)
				begin
					st_next.fall_cnt = fall_idx;
					st_next.dout = 1'b0;
					if (fall_idx == 5'h01)
					begin
						// channel change waits for a conversion boundary
						st_next.chan_cur = st_reg.chan_pend;
						st_next.track = 1'b1;
						st_next.doze = 1'b0;
					end
					if (fall_idx == 5'(asc_pkg::LEAD_ZEROS))
					begin
						st_next.track = 1'b0;
						st_next.res_shift = head.valid ? head.data : asc_pkg::RESULT_EMPTY;
					end
					if (fall_idx > 5'(asc_pkg::LEAD_ZEROS) && fall_idx <= 5'(asc_pkg::RES_LAST_EDGE))
					begin
						st_next.dout = st_reg.res_shift[asc_pkg::RESULT_W-1];
						st_next.res_shift = {st_reg.res_shift[asc_pkg::RESULT_W-2:0], 1'b0};
					end
					if (fall_idx == 5'(asc_pkg::CONV_EDGES))
						st_next.doze = 1'b1;
				end
			end
		end
	end

	// state register; reset doubles as power-up
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.cs_p <= 3'h7;
			st_reg.chan_pend <= asc_pkg::CHAN_RESET;
			st_reg.chan_cur <= asc_pkg::CHAN_RESET;
		end
		else
			st_reg <= st_next;
	end

	// ======================================================================
	// checks
	a_deselect_no_drive: assert property (@(posedge clk) disable iff (!rst_n) st_reg.cs_p[1] |-> !dout_oe && !powered)
		else $error("output driven or powered while deselected");
	// only the second sync flop is read; a select that rose meanwhile excuses the check
	a_power_follows_cs: assert property (@(posedge clk) disable iff (!rst_n) ce && $fell(st_reg.cs_p[1]) |=> st_reg.cs_p[1] || powered)
		else $error("not powered after select fell");
	a_doze_after_16: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx == 5'h10 |=> !powered)
		else $error("still powered after sixteenth falling edge");
	a_wake_on_first: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx == 5'h01 |=> st_reg.cs_p[1] || (powered && track))
		else $error("no wake on first falling edge");
	a_lead_zeros: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx <= 5'h04 |=> !dout)
		else $error("leading bit not zero");
	a_trail_zeros: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx >= 5'h0f |=> !dout)
		else $error("trailing bit not zero");
	a_result_msb: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx == 5'h05 |=> dout == $past(st_reg.res_shift[9]))
		else $error("result msb not sent on fifth edge");
	a_result_load: assert property (@(posedge clk) disable iff (!rst_n) head_pop && head.valid |=> st_reg.res_shift == $past(head.data))
		else $error("result not taken from buffer");
	a_conv_count: assert property (@(posedge clk) disable iff (!rst_n) st_reg.fall_cnt <= 5'h10)
		else $error("conversion longer than sixteen clocks");
	a_ctl_capture: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_rise && st_reg.rise_cnt == 4'h7 |=> st_reg.chan_pend == $past(ctl_byte[5:3]) && sample_chan == $past(sample_chan))
		else $error("channel capture wrong or applied early");
	a_reset_chan: assert property (@(posedge clk) $rose(rst_n) |-> sample_chan == 3'h0)
		else $error("channel not first input after reset");
	// the falling count wraps from sixteen back to one in continuous mode
	a_fall_wrap: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && st_reg.fall_cnt == 5'h10 |=> st_reg.fall_cnt == 5'h01)
		else $error("falling count did not wrap to one");
	// each detected falling edge below a count of sixteen advances the count by exactly one
	a_fall_step: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && st_reg.fall_cnt != 5'h10 |=> st_reg.fall_cnt == $past(st_reg.fall_cnt) + 5'h01)
		else $error("falling count skipped");
	// each detected rising edge advances the rise count by one
	a_rise_step: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_rise |=> st_reg.rise_cnt == $past(st_reg.rise_cnt) + 4'h1)
		else $error("rising count skipped");
	// the channel only moves at a conversion boundary
	a_chan_hold: assert property (@(posedge clk) disable iff (!rst_n) ce && !(sclk_fall && fall_idx == 5'h01) |=> sample_chan == $past(sample_chan))
		else $error("channel changed inside a conversion");
	// at the boundary the pending channel takes over
	a_chan_apply: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx == 5'h01 |=> sample_chan == $past(st_reg.chan_pend))
		else $error("pending channel not applied");
	// tracking ends when the hold starts on the fourth falling edge
	a_track_close: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx == 5'h04 |=> !track)
		else $error("track still high after fourth falling edge");
	// a low enable freezes every flop, sync stages included
	a_freeze_all: assert property (@(posedge clk) disable iff (!rst_n) !ce |=> st_reg == $past(st_reg))
		else $error("state moved while enable low");
	// result bits leave msb first from the shifter
	a_result_bits: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_fall && fall_idx > 5'h04 && fall_idx <= 5'h0e |=> dout == $past(st_reg.res_shift[9]))
		else $error("result bit out of order");
	// deselect clears counters and tracking so the next frame starts clean
	a_deselect_clear: assert property (@(posedge clk) disable iff (!rst_n) ce && !cs_low |=> st_reg.fall_cnt == 5'h00 && st_reg.rise_cnt == 4'h0 && !track)
		else $error("counters not cleared while deselected");
	// an empty buffer at the hold start sends an all-zero word
	a_empty_zero: assert property (@(posedge clk) disable iff (!rst_n) head_pop && !head.valid |=> st_reg.res_shift == 10'h000)
		else $error("stale result sent from empty buffer");
	// once dozing, power stays off until the next first falling edge or a new select after a deselect
	a_doze_hold: assert property (@(posedge clk) disable iff (!rst_n) ce && st_reg.doze && !sclk_fall |=> !powered)
		else $error("woke from doze without a falling edge");
	// control bits enter the shifter from the synced data pin
	a_ctl_shift: assert property (@(posedge clk) disable iff (!rst_n) ce && sclk_rise && st_reg.rise_cnt < 4'h8 |=> st_reg.ctl_shift[0] == $past(st_reg.din_p[1]))
		else $error("control bit not shifted in");
endmodule
`default_nettype wire

//--- testbench/asc_host_model.sv
/*
 * host serial master model: frames conversions on select, clock and data pins.
 * assumes clk is the 50 MHz bench clock; each serial clock level lasts 8 clk.
 */
`timescale 1ns/100ps
`default_nettype none
module asc_host_model
(
	// bench clock
	input wire logic clk,
	// pins toward the block
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic powered,
	input wire logic track,
	input wire logic [2:0] sample_chan,
	// captured conversion
	output logic got,
	output logic [50:0] got_bits
);
	logic [50:0] cap;
	// ======================================================================
	// idle levels: clock parked high outside frames
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
		got = 1'b0;
		got_bits = '0;
	end
	// select falls with the clock high so fall one is a real clock edge
	task automatic open_frame();
		cs_n = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask
	// sixteen clock periods; samples at the end of each low half, when settled
	task automatic convert(input logic [7:0] ctl);
		for (int i = 0; i < 16; i++)
		begin
			sclk = 1'b0;
			din = (i < 8) ? ctl[7 - i] : ~din;
			repeat (8) @(posedge clk);
			#1;
			if (i == 0)
				cap[50:48] = sample_chan;
			cap[47 - i] = dout_oe ? dout : 1'bx; // undriven line must not pass
			cap[31 - i] = powered;
			cap[15 - i] = track;
			sclk = 1'b1;
			repeat (8) @(posedge clk);
			#1;
		end
		got_bits = cap;
		got = 1'b1;
		@(posedge clk);
		#1;
		got = 1'b0;
	endtask
	// raising select between conversions trades throughput for power
	task automatic close_frame();
		cs_n = 1'b1;
		din = ~din;
		repeat (6) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

//--- testbench/test_asc_ctrl.sv
/*
 * self-checking bench for the converter control block.
 * assumes the host model reports each conversion; the bench feeds core results.
 */
`timescale 1ns/100ps
`default_nettype none
module test_asc_ctrl;
	logic clk, rst_n, cs_n, sclk, din, dout, dout_oe, track, powered, got;
	logic res_valid, res_ready;
	logic [2:0] sample_chan, chan_pend;
	logic [9:0] res_data, w0, w1;
	logic [7:0] ctl;
	logic [50:0] got_bits;
	logic [50:0] exp_q[$];
	int n_fail = 0;
	int compares = 0;
	int seed = 32'h4c68;
	asc_ctrl asc_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .sample_chan(sample_chan), .track(track), .powered(powered),
		.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
	asc_host_model asc_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
		.dout_oe(dout_oe), .powered(powered), .track(track), .sample_chan(sample_chan), .got(got),
		.got_bits(got_bits));
	// ======================================================================
	// shared tasks
	task automatic check(input string what, input logic [50:0] exp, input logic [50:0] seen);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// hold valid until ready is seen high at an edge
	task automatic push(input logic [9:0] w);
		res_valid = 1'b1;
		res_data = w;
		while (res_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		res_valid = 1'b0;
		// let an edge pass so a following push does not re-raise valid in this step
		@(posedge clk);
		#1;
	endtask
	// note: channel, 4 zeros, result, 2 zeros; powered minus fall 16; track on falls 1-3
	task automatic conv(input logic [9:0] w, input logic [7:0] c);
		exp_q.push_back({chan_pend, 4'h0, w, 2'h0, 16'hfffe, 16'he000});
		chan_pend = c[5:3];
		asc_host_model_i.convert(c);
	endtask
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ======================================================================
	// clock, watchdog, result monitor
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	always @(posedge clk)
		if (got === 1'b1)
			check("conversion", exp_q.pop_front(), got_bits);
	// ======================================================================
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		res_valid = 1'b0;
		res_data = 10'h000;
		chan_pend = 3'h0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		@(posedge clk);
		#1;
		check("reset state", 51'h1, {43'h0, dout, dout_oe, powered, track, sample_chan, res_ready});
		$display("test reset done");
		// two words fill the buffer; third conversion finds it empty and sends zeros
		w0 = 10'($random(seed));
		w1 = 10'($random(seed));
		push(w0);
		push(w1);
		check("full buffer", 51'h0, {50'h0, res_ready});
		asc_host_model_i.open_frame();
		conv(w0, 8'($random(seed)));
		conv(w1, 8'($random(seed)));
		conv(10'h000, 8'($random(seed)));
		asc_host_model_i.close_frame();
		check("idle pins", 51'h0, {48'h0, dout_oe, powered, track});
		$display("test continuous done");
		// one conversion per frame, every channel code in turn
		for (int c = 0; c < 9; c++)
		begin
			w0 = 10'($random(seed));
			ctl = 8'($random(seed));
			ctl[5:3] = 3'(c);
			push(w0);
			asc_host_model_i.open_frame();
			conv(w0, ctl);
			asc_host_model_i.close_frame();
			check("idle pins", 51'h0, {48'h0, dout_oe, powered, track});
		end
		$display("test burst done");
		end_sim();
	end
endmodule
`default_nettype wire
